// file: core/csp_defines.vh
/*
 * register map constants for the clock sync profile register bank.
 * assumes byte-wide register access over a plain strobe port.
 */
`ifndef CSP_DEFINES_VH
`define CSP_DEFINES_VH

// ---------------------------------------------------------------------
// profile 3 byte offsets, profile 7 alias offset and power-down address
// ---------------------------------------------------------------------
`define CSP_PRIO_ADDR        12'h6B2
`define CSP_INNER_TOL_ADDR   12'h6BA
`define CSP_OUTER_TOL_ADDR   12'h6BD
`define CSP_VALID_TIME_ADDR  12'h6C0
`define CSP_REDET_TIME_ADDR  12'h6C2
`define CSP_COEFF_ADDR       12'h6C4
`define CSP_RDIV_ADDR        12'h6D0
`define CSP_SDIV_ADDR        12'h6D4
`define CSP_FRAC_ADDR        12'h6D8
`define CSP_PH_LIMIT_ADDR    12'h6DB
`define CSP_PH_FILL_ADDR     12'h6DD
`define CSP_PH_DRAIN_ADDR    12'h6DE
`define CSP_FQ_LIMIT_ADDR    12'h6DF
`define CSP_FQ_FILL_ADDR     12'h6E2
`define CSP_FQ_DRAIN_ADDR    12'h6E3
`define CSP_PROF3_BASE       12'h6B2
`define CSP_PROF3_END        12'h6FF
`define CSP_ALIAS_OFFSET     12'h100
`define CSP_PWRDN_ADDR       12'hA00

// ---------------------------------------------------------------------
// field positions, counts, feedback minimum and reset value
// ---------------------------------------------------------------------
`define CSP_BYTE_SPAN        7'd78
`define CSP_PWRDN_RESET_BIT  7
`define CSP_PWRDN_SYSTEM_CLOCK_INPUT_BIT 5
`define CSP_PH_UNIT_BIT      7
`define CSP_SDIV_MIN         20'h00007
`define CSP_RESET_VAL        8'h00

`endif

// file: core/csp_regs.v
/*
 * byte-addressed register bank for one reference profile (profile 3,
 * aliased as profile 7) plus the reset/clock power-down control bits.
 * assumes a single-cycle strobe master on mclk_i that never needs wait
 * states; read data appears the cycle after the read strobe.
 */
`timescale 1ns/1ps
`include "csp_defines.vh"

module csp_regs (
    input  wire        mclk_i,
    input  wire        rst_n_i,
    input  wire [11:0] addr_i,
    input  wire [7:0]  wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [7:0]  rdata_o,
    output reg         soft_reset_o,
    output reg         system_clock_input_pd_o,
    output reg         phase_unit_ns_o,
    output reg  [30:0] input_divide_ratio_o,
    output reg  [20:0] feedback_divide_ratio_o,
    output reg         feedback_too_small_o,
    output reg  [19:0] inner_tol_o,
    output reg  [19:0] outer_tol_o,
    output reg  [15:0] phase_lock_limit_o,
    output reg  [23:0] freq_lock_limit_o
);

    // -----------------------------------------------------------------
    // byte storage
    // -----------------------------------------------------------------
    // one flat array covers 0x6B2..0x6FF; per-byte masks give the holes
    reg  [7:0]  mem_ff [0:77];
    reg  [7:0]  pwrdn_ff;
    reg  [7:0]  nxt_rdata;
    reg         hit_prof;
    reg  [6:0]  idx;
    reg  [11:0] local_addr;
    reg  [11:0] offs;
    integer     i;

    // profile 7 maps onto the same storage as profile 3
    function [11:0] fold_alias;
        input [11:0] a;
        begin
            if (a >= (`CSP_PROF3_BASE + `CSP_ALIAS_OFFSET) &&
                a <= (`CSP_PROF3_END + `CSP_ALIAS_OFFSET)) begin
                fold_alias = a - `CSP_ALIAS_OFFSET;
            end else begin
                fold_alias = a;
            end
        end
    endfunction

    // writable bits per byte; zeros are unused bits or spare space
    function [7:0] byte_mask;
        input [11:0] a;
        begin
            case (a)
                12'h6B2: byte_mask = 8'hBF;
                12'h6B3: byte_mask = 8'hFF;
                12'h6B4: byte_mask = 8'hFF;
                12'h6B5: byte_mask = 8'hFF;
                12'h6B6: byte_mask = 8'hFF;
                12'h6B7: byte_mask = 8'hFF;
                12'h6B8: byte_mask = 8'h00;
                12'h6B9: byte_mask = 8'h00;
                12'h6BA: byte_mask = 8'hFF;
                12'h6BB: byte_mask = 8'hFF;
                12'h6BC: byte_mask = 8'h0F;
                12'h6BD: byte_mask = 8'hFF;
                12'h6BE: byte_mask = 8'hFF;
                12'h6BF: byte_mask = 8'h0F;
                12'h6C0: byte_mask = 8'hFF;
                12'h6C1: byte_mask = 8'hFF;
                12'h6C2: byte_mask = 8'hFF;
                12'h6C3: byte_mask = 8'hFF;
                12'h6C4: byte_mask = 8'hFF;
                12'h6C5: byte_mask = 8'hFF;
                12'h6C6: byte_mask = 8'hFF;
                12'h6C7: byte_mask = 8'hFF;
                12'h6C8: byte_mask = 8'hFF;
                12'h6C9: byte_mask = 8'h7F;
                12'h6CA: byte_mask = 8'hFF;
                12'h6CB: byte_mask = 8'hFF;
                12'h6CC: byte_mask = 8'h3F;
                12'h6CD: byte_mask = 8'hFF;
                12'h6CE: byte_mask = 8'hFF;
                12'h6CF: byte_mask = 8'hFF;
                12'h6D0: byte_mask = 8'hFF;
                12'h6D1: byte_mask = 8'hFF;
                12'h6D2: byte_mask = 8'hFF;
                12'h6D3: byte_mask = 8'h3F;
                12'h6D4: byte_mask = 8'hFF;
                12'h6D5: byte_mask = 8'hFF;
                12'h6D6: byte_mask = 8'h0F;
                12'h6D7: byte_mask = 8'h00;
                12'h6D8: byte_mask = 8'hFF;
                12'h6D9: byte_mask = 8'hF3;
                12'h6DA: byte_mask = 8'h3F;
                12'h6DB: byte_mask = 8'hFF;
                12'h6DC: byte_mask = 8'hFF;
                12'h6DD: byte_mask = 8'hFF;
                12'h6DE: byte_mask = 8'hFF;
                12'h6DF: byte_mask = 8'hFF;
                12'h6E0: byte_mask = 8'hFF;
                12'h6E1: byte_mask = 8'hFF;
                12'h6E2: byte_mask = 8'hFF;
                12'h6E3: byte_mask = 8'hFF;
                // spare tail 0x6E4..0x6FF and anything unmapped
                default: byte_mask = 8'h00;
            endcase
        end
    endfunction

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    always @* begin
        local_addr = fold_alias(addr_i);
        hit_prof   = (local_addr >= `CSP_PROF3_BASE) &&
                     (local_addr <= `CSP_PROF3_END);
        // subtract at full width, then keep the in-range index bits
        offs       = local_addr - `CSP_PROF3_BASE;
        idx        = hit_prof ? offs[6:0] : 7'd0;
    end

    // -----------------------------------------------------------------
    // write path
    // -----------------------------------------------------------------
    // the soft reset bit never clears this storage
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (i = 0; i < 78; i = i + 1) begin
                mem_ff[i] <= `CSP_RESET_VAL;
            end
            pwrdn_ff <= `CSP_RESET_VAL;
        end else if (wr_i) begin
            if (hit_prof) begin
                mem_ff[idx] <= wdata_i & byte_mask(local_addr);
            end
            if (addr_i == `CSP_PWRDN_ADDR) begin
                // bits 6 and 4..0 belong to other blocks and read zero here
                pwrdn_ff <= wdata_i & 8'hA0;
            end
        end
    end

    // -----------------------------------------------------------------
    // read path
    // -----------------------------------------------------------------
    always @* begin
        nxt_rdata = 8'h00;
        if (hit_prof) begin
            nxt_rdata = mem_ff[idx];
        end else if (addr_i == `CSP_PWRDN_ADDR) begin
            nxt_rdata = pwrdn_ff;
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? nxt_rdata : 8'h00;
        end
    end

    // -----------------------------------------------------------------
    // decoded fields to the datapath
    // -----------------------------------------------------------------
    // registered so every output comes from a flop; one cycle of lag
    // after a write is harmless for quasi-static configuration
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            soft_reset_o            <= 1'b0;
            system_clock_input_pd_o <= 1'b0;
            phase_unit_ns_o         <= 1'b0;
        end else begin
            soft_reset_o <= pwrdn_ff[`CSP_PWRDN_RESET_BIT];
            system_clock_input_pd_o <=
                pwrdn_ff[`CSP_PWRDN_SYSTEM_CLOCK_INPUT_BIT];
            phase_unit_ns_o <=
                mem_ff[0][`CSP_PH_UNIT_BIT];
        end
    end

    // -----------------------------------------------------------------
    // divider ratios
    // -----------------------------------------------------------------
    // the plus-one is done here so the datapath never sees a zero ratio
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            input_divide_ratio_o <= 31'h00000001;
        end else begin
            input_divide_ratio_o <= {1'b0, mem_ff[33][5:0], mem_ff[32],
                mem_ff[31], mem_ff[30]} + 31'h00000001;
        end
    end

    // a too-small value is only flagged; software must keep it legal
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            feedback_divide_ratio_o <= 21'h000001;
            feedback_too_small_o    <= 1'b1;
        end else begin
            feedback_divide_ratio_o <= {1'b0, mem_ff[36][3:0], mem_ff[35],
                mem_ff[34]} + 21'h000001;
            feedback_too_small_o <= {mem_ff[36][3:0], mem_ff[35],
                mem_ff[34]} < `CSP_SDIV_MIN;
        end
    end

    // -----------------------------------------------------------------
    // tolerance and lock windows
    // -----------------------------------------------------------------
    // multi-byte fields are not updated atomically; a reader may see a
    // mix of old and new bytes while software is part way through
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            inner_tol_o <= 20'h00000;
            outer_tol_o <= 20'h00000;
        end else begin
            inner_tol_o <= {mem_ff[10][3:0], mem_ff[9], mem_ff[8]};
            outer_tol_o <= {mem_ff[13][3:0], mem_ff[12],
                mem_ff[11]};
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_lock_limit_o <= 16'h0000;
        end else begin
            phase_lock_limit_o <= {mem_ff[42], mem_ff[41]};
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            freq_lock_limit_o <= 24'h000000;
        end else begin
            freq_lock_limit_o <= {mem_ff[47], mem_ff[46],
                mem_ff[45]};
        end
    end

    // coefficient, timer, rate and fraction bytes are held in mem_ff
    // indices 14..29, 38..40, 43..44, 48..49 with the masks above

endmodule // csp_regs

// file: bench/csp_regs_checker.sv
/* checker for the profile register bank port.
   assumes bind onto csp_regs; one clock, async active-low reset. */
`timescale 1ns/1ps
module csp_regs_checker (
    input wire        mclk_i,
    input wire        rst_n_i,
    input wire [11:0] addr_i,
    input wire [7:0]  wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [7:0]  rdata_o,
    input wire        soft_reset_o,
    input wire        system_clock_input_pd_o,
    input wire        phase_unit_ns_o,
    input wire [30:0] input_divide_ratio_o,
    input wire [20:0] feedback_divide_ratio_o,
    input wire        feedback_too_small_o,
    input wire [19:0] inner_tol_o,
    input wire [19:0] outer_tol_o,
    input wire [15:0] phase_lock_limit_o,
    input wire [23:0] freq_lock_limit_o
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // decoded outputs trail storage, so two idle cycles are needed
    sequence s_quiet;
        !wr_i ##1 !wr_i;
    endsequence
    AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not idle");
    AST_SPARE: assert property (rd_i && addr_i >= 12'h6E4 &&
        addr_i <= 12'h6FF |=> rdata_o == 8'h00) else $error("spare read");
    AST_FRAC: assert property (rd_i && addr_i == 12'h6D9 |=>
        rdata_o[3:2] == 2'b00) else $error("fraction pad bits set");
    AST_PD_MASK: assert property (rd_i && addr_i == 12'hA00 |=>
        (rdata_o & 8'h5F) == 8'h00) else $error("power byte mask");
    AST_SMALL: assert property (feedback_too_small_o ==
        (feedback_divide_ratio_o < 21'd8)) else $error("feedback limit");
    AST_R_NZ: assert property (input_divide_ratio_o != 31'h0)
        else $error("input ratio zero");
    AST_HOLD: assert property (s_quiet |=> $stable(inner_tol_o) &&
        $stable(outer_tol_o) && $stable(freq_lock_limit_o))
        else $error("field moved without write");
    AST_SOFT: assert property (wr_i && addr_i == 12'hA00 |-> ##2
        soft_reset_o == $past(wdata_i[7], 2) &&
        system_clock_input_pd_o == $past(wdata_i[5], 2))
        else $error("power byte outputs");
    AST_UNIT: assert property (wr_i && (addr_i == 12'h6B2 ||
        addr_i == 12'h7B2) |-> ##2 phase_unit_ns_o == $past(wdata_i[7], 2))
        else $error("phase unit");
endmodule // csp_regs_checker

bind csp_regs csp_regs_checker chk_u (.mclk_i, .rst_n_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .soft_reset_o,
    .system_clock_input_pd_o, .phase_unit_ns_o, .input_divide_ratio_o,
    .feedback_divide_ratio_o, .feedback_too_small_o, .inner_tol_o,
    .outer_tol_o, .phase_lock_limit_o, .freq_lock_limit_o);

// file: bench/clock_sync_profile_regs_test.sv
/* bench for the profile register bank: byte writes and reads.
   assumes csp_regs with checker bound; fixed latencies, no waits. */
`timescale 1ns/1ps
module clock_sync_profile_regs_test;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [7:0]  wdata_i = 8'h00;
    wire  [7:0]  rdata_o;
    wire         soft_reset_o, system_clock_input_pd_o, phase_unit_ns_o;
    wire  [30:0] input_divide_ratio_o;
    wire  [20:0] feedback_divide_ratio_o;
    wire         feedback_too_small_o;
    wire  [19:0] inner_tol_o, outer_tol_o;
    wire  [15:0] phase_lock_limit_o;
    wire  [23:0] freq_lock_limit_o;
    int          err_total = 0, tests_run = 0;
    // entries are {address, written byte, expected read}
    logic [27:0] tab [0:29] = '{28'h6BA1212, 28'h6BB3434, 28'h6BCF505,
        28'h6BD0101, 28'h6BE0202, 28'h6BFFF0F, 28'h6C08181, 28'h6C14242,
        28'h6C25555, 28'h6C6FFFF, 28'h6C9FF7F, 28'h6CCFF3F, 28'h6CE5A5A,
        28'h6CFA5A5, 28'h6D9FFF3, 28'h6DAFF3F, 28'h6DBCDCD, 28'h6DCABAB,
        28'h6DD7777, 28'h6DF1111, 28'h6E02222, 28'h6E13333, 28'h6E39999,
        28'h6E4FF00, 28'h6FFFF00, 28'h6B8FF00, 28'h700FF00, 28'hA01FF00,
        28'h6B2FFBF, 28'hA00FFA0};
    csp_regs dut_u (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .soft_reset_o, .system_clock_input_pd_o,
        .phase_unit_ns_o, .input_divide_ratio_o, .feedback_divide_ratio_o,
        .feedback_too_small_o, .inner_tol_o, .outer_tol_o,
        .phase_lock_limit_o, .freq_lock_limit_o);
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    // read data stands only one cycle, so it is sampled right then
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    task automatic settle;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        settle();
        chk(input_divide_ratio_o, 32'h1);
        chk(feedback_too_small_o, 32'h1);
        chk({soft_reset_o, system_clock_input_pd_o}, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 4; i++) wr(12'h6D0 + i, 8'hFF);
        settle();
        chk(input_divide_ratio_o, 32'h40000000);
        rd(12'h7D3, 8'h3F);
        wr(12'h6D4, 8'h06);
        settle();
        chk({feedback_too_small_o, feedback_divide_ratio_o}, 32'h200007);
        wr(12'h6D4, 8'h07);
        wr(12'h6D6, 8'hFF);
        settle();
        chk({feedback_too_small_o, feedback_divide_ratio_o}, 32'hF0008);
        rd(12'h6D6, 8'h0F);
        wr(12'h6D7, 8'hFF);
        rd(12'h6D7, 8'h00);
        $display("divider test done");
        foreach (tab[i]) wr(tab[i][27:16], tab[i][15:8]);
        foreach (tab[i]) rd(tab[i][27:16], tab[i][7:0]);
        settle();
        chk({inner_tol_o, 12'h000}, 32'h53412000);
        chk(outer_tol_o, 32'hF0201);
        chk(phase_lock_limit_o, 32'hABCD);
        chk(freq_lock_limit_o, 32'h332211);
        chk({phase_unit_ns_o, soft_reset_o, system_clock_input_pd_o}, 32'h7);
        rd(12'h7BA, 8'h12);
        $display("map test done");
        wr(12'hA00, 8'h20);
        settle();
        chk({soft_reset_o, system_clock_input_pd_o}, 32'h1);
        rd(12'h6BA, 8'h12);
        wr(12'hA00, 8'h00);
        settle();
        chk(system_clock_input_pd_o, 32'h0);
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        settle();
        @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(12'h6BA, 8'h00);
        $display("control test done");
        results();
    end
endmodule // clock_sync_profile_regs_test
